// ==== rtl/pbc_clock_gen.sv ====
// Clock generator control: loop programming registers and glitch-free base clock selector.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "pbc_consts.svh"
// Functional notes
// RULE1 - Multiplier zero behaves exactly like one.
// RULE2 - Range factor zero disables loop, forces crystal.
// RULE3 - Source change: output static for three edges each.
// RULE4 - Output toggles per selected edge: divide by two.
// RULE5 - Select bit set picks VCO, clear crystal.
// RULE6 - VCO selection blocked while loop is off.
// RULE7 - Loop stays on while VCO is selected.
// RULE8 - Loop and select changes need separate writes.
// RULE9 - Software sets VCO at four times bus.
// RULE10 - Software picks multiplier as rounded ratio.
// RULE11 - Software writes exponent per VCO band.
// RULE12 - Software never writes exponent three.
// RULE13 - Software writes multiplier across high, low.
// RULE14 - Low multiplier rewritten before loop enable.
// RULE15 - Software writes linear range factor binary.
// RULE16 - Software keeps center near actual VCO.
// RULE17 - Reset: loop on, crystal selected.
// RULE18 - Programming registers read-only while loop on.
// RULE19 - Select forced clear when loop off/range zero.
// RULE20 - Old source drained before new one enabled.

module pbc_clock_gen (
  input wire logic sys_clk,
  input wire logic rst_n,
  pbc_reg_if.device regPort,
  input wire logic crystalClock,
  input wire logic vcoClock,
  output logic baseClockOut,
  output logic loopEnable,
  output logic [11:0] feedbackMultiplier,
  output logic [1:0] rangeExponent,
  output logic [7:0] linearRange,
  output logic vcoActive,
  output logic switching
);

  // ----------------------------------------------------------------
  // Programming registers
  // ----------------------------------------------------------------
  logic loopOn;
  logic baseSourceSelect;
  logic [1:0] rangeExponentBits;
  logic [3:0] multHigh;
  logic [7:0] multLow;
  logic [7:0] linearRangeField;
  logic rangeZero;
  logic wrLoop;
  logic [7:0] wd;

  assign rangeZero = (linearRangeField == 8'h00);
  assign wrLoop = regPort.regWr && (regPort.regAddr == `PBC_ADDR_LOOP_CONTROL);
  assign wd = regPort.regWdata;

  // Both control bits are judged against their values before this write, so a
  // single write switches both only when it turns the loop off and selects the VCO.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loopOn <= 1'b1; // RULE17
      baseSourceSelect <= 1'b0; // RULE17
    end
    else
    begin
      if (wrLoop && !baseSourceSelect) // RULE7 RULE8
      begin
        loopOn <= wd[`PBC_BIT_LOOP_ON];
      end
      if (!loopOn || rangeZero) // RULE19 RULE2
      begin
        baseSourceSelect <= 1'b0;
      end
      else if (wrLoop) // RULE5 RULE6 RULE8
      begin
        baseSourceSelect <= wd[`PBC_BIT_BASE_SELECT];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rangeExponentBits <= `PBC_RST_EXP;
      multHigh <= `PBC_RST_MULT_HIGH;
      multLow <= `PBC_RST_MULT_LOW;
      linearRangeField <= `PBC_RST_VCO_RANGE;
    end
    else if (regPort.regWr && !loopOn) // RULE18
    begin
      unique case (regPort.regAddr)
        `PBC_ADDR_LOOP_CONTROL: rangeExponentBits <= wd[`PBC_EXP_HI:`PBC_EXP_LO];
        `PBC_ADDR_MULT_HIGH: multHigh <= wd[3:0];
        `PBC_ADDR_MULT_LOW: multLow <= wd;
        `PBC_ADDR_VCO_RANGE: linearRangeField <= wd;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regPort.regRdata <= 8'h00;
    end
    else if (regPort.regRd)
    begin
      unique case (regPort.regAddr)
        `PBC_ADDR_LOOP_CONTROL: regPort.regRdata <= {2'h0, loopOn, baseSourceSelect,
                                                     2'h0, rangeExponentBits};
        `PBC_ADDR_MULT_HIGH: regPort.regRdata <= {4'h0, multHigh};
        `PBC_ADDR_MULT_LOW: regPort.regRdata <= multLow;
        `PBC_ADDR_VCO_RANGE: regPort.regRdata <= linearRangeField;
        default: regPort.regRdata <= 8'h00;
      endcase
    end
    else
    begin
      regPort.regRdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Settings handed to the analog loop
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      loopEnable <= 1'b0;
      feedbackMultiplier <= 12'h001;
      rangeExponent <= `PBC_RST_EXP;
      linearRange <= `PBC_RST_VCO_RANGE;
    end
    else
    begin
      loopEnable <= loopOn && !rangeZero; // RULE2
      if ({multHigh, multLow} == 12'h000) // RULE1
      begin
        feedbackMultiplier <= 12'h001;
      end
      else
      begin
        feedbackMultiplier <= {multHigh, multLow};
      end
      rangeExponent <= rangeExponentBits;
      linearRange <= linearRangeField;
    end
  end

  // ----------------------------------------------------------------
  // Source clock synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [2:0] xtalSync;
  logic [2:0] vcoSync;
  logic xtalRise;
  logic vcoRise;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xtalSync <= 3'h0;
      vcoSync <= 3'h0;
    end
    else
    begin
      xtalSync <= {xtalSync[1:0], crystalClock};
      vcoSync <= {vcoSync[1:0], vcoClock};
    end
  end

  assign xtalRise = xtalSync[1] && !xtalSync[2];
  assign vcoRise = vcoSync[1] && !vcoSync[2];

  // ----------------------------------------------------------------
  // Transition control and divide by two
  // ----------------------------------------------------------------
  pbc_pkg::pbc_switch_state_type swState;
  logic [1:0] edgeCount;
  logic oldRise;
  logic curRise;

  // The drain side counts the source being left, the fill side the one taken.
  assign curRise = vcoActive ? vcoRise : xtalRise;
  assign oldRise = curRise;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      swState <= pbc_pkg::SW_RUN;
      edgeCount <= 2'h0;
      vcoActive <= 1'b0;
      switching <= 1'b0;
    end
    else
    begin
      unique case (swState)
        pbc_pkg::SW_RUN:
        begin
          edgeCount <= 2'h0;
          if (baseSourceSelect != vcoActive) // RULE20
          begin
            swState <= pbc_pkg::SW_DRAIN_OLD;
            switching <= 1'b1;
          end
        end
        pbc_pkg::SW_DRAIN_OLD:
        begin
          // A stopped VCO would never finish draining, so a disabled loop ends it.
          if ((oldRise && edgeCount == `PBC_SWITCH_EDGES - 2'h1) ||
              (vcoActive && !loopEnable)) // RULE3 RULE20
          begin
            swState <= pbc_pkg::SW_FILL_NEW;
            vcoActive <= baseSourceSelect;
            edgeCount <= 2'h0;
          end
          else if (oldRise)
          begin
            edgeCount <= edgeCount + 2'h1;
          end
        end
        pbc_pkg::SW_FILL_NEW:
        begin
          if (curRise && edgeCount == `PBC_SWITCH_EDGES - 2'h1) // RULE3
          begin
            swState <= pbc_pkg::SW_RUN;
            switching <= 1'b0;
            edgeCount <= 2'h0;
          end
          else if (curRise)
          begin
            edgeCount <= edgeCount + 2'h1;
          end
        end
        default:
        begin
          swState <= pbc_pkg::SW_RUN;
          switching <= 1'b0;
        end
      endcase
    end
  end

  // The output only moves while running, so it is static during a change.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      baseClockOut <= 1'b0;
    end
    else if (swState == pbc_pkg::SW_RUN && curRise) // RULE4 RULE3
    begin
      baseClockOut <= !baseClockOut;
    end
  end

endmodule

`default_nettype wire

// ==== include/pbc_consts.svh ====
// Offsets, field positions, reset values and timing counts of the clock generator control.
`ifndef PBC_CONSTS_SVH
`define PBC_CONSTS_SVH

// Device register offsets on the shared register port.
`define PBC_ADDR_LOOP_CONTROL 3'h0
`define PBC_ADDR_MULT_HIGH 3'h1
`define PBC_ADDR_MULT_LOW 3'h2
`define PBC_ADDR_VCO_RANGE 3'h3

// Loop control register fields.
`define PBC_BIT_LOOP_ON 5
`define PBC_BIT_BASE_SELECT 4
`define PBC_EXP_HI 1
`define PBC_EXP_LO 0

// Device reset values and the forbidden exponent.
`define PBC_RST_MULT_HIGH 4'h0
`define PBC_RST_MULT_LOW 8'h40
`define PBC_RST_VCO_RANGE 8'h40
`define PBC_RST_EXP 2'h0
`define PBC_EXP_FORBIDDEN 2'h3

// Source edges counted on each side of a source change.
`define PBC_SWITCH_EDGES 2'h3

// Controller user register offsets and control bit positions.
`define PBC_USR_CTRL 3'h0
`define PBC_USR_EXP 3'h1
`define PBC_USR_MULT_HIGH 3'h2
`define PBC_USR_MULT_LOW 3'h3
`define PBC_USR_RANGE 3'h4
`define PBC_USR_STATUS 3'h5
`define PBC_USR_BIT_ON 0
`define PBC_USR_BIT_SEL 1

`endif

// ==== include/pbc_pkg.sv ====
// Types shared by the clock generator control and its controller.
`default_nettype none

package pbc_pkg;

  typedef enum logic [1:0] {
    SW_RUN,
    SW_DRAIN_OLD,
    SW_FILL_NEW
  } pbc_switch_state_type;

  typedef enum logic [1:0] {
    CT_IDLE,
    CT_SECOND
  } pbc_ctrl_state_type;

  typedef logic [7:0] pbc_byte_type;

endpackage

`default_nettype wire

// ==== include/pbc_reg_if.sv ====
// Register port between the controller and the clock generator control.
`timescale 1ns/100ps
`default_nettype none

interface pbc_reg_if;
  logic [2:0] regAddr;
  logic [7:0] regWdata;
  logic regWr;
  logic regRd;
  logic [7:0] regRdata;

  modport device (
    input regAddr,
    input regWdata,
    input regWr,
    input regRd,
    output regRdata
  );

  modport ctrl (
    output regAddr,
    output regWdata,
    output regWr,
    output regRd,
    input regRdata
  );
endinterface

`default_nettype wire

// ==== rtl/pbc_controller.sv ====
// Controller that programs the clock generator control on behalf of software.
`timescale 1ns/100ps
`default_nettype none
`include "pbc_consts.svh"

module pbc_controller (
  input wire logic sys_clk,
  input wire logic rst_n,
  pbc_reg_if.ctrl regPort,
  input wire logic [2:0] usrAddr,
  input wire logic [7:0] usrWdata,
  input wire logic usrWr,
  input wire logic usrRd,
  output logic [7:0] usrRdata
);

  // ----------------------------------------------------------------
  // Shadows of what was sent to the device
  // ----------------------------------------------------------------
  pbc_pkg::pbc_ctrl_state_type state;
  logic shadowOn;
  logic shadowSel;
  logic [1:0] shadowExp;
  logic [3:0] shadowMultHigh;
  logic [7:0] shadowMultLow;
  logic [7:0] shadowRange;
  logic lowWritten;
  logic cmdError;
  logic rdSeen;
  logic [7:0] devControl;
  pbc_pkg::pbc_byte_type secondData;
  logic newOn;
  logic newSel;
  logic splitNeeded;
  logic enableRefused;

  assign newOn = usrWdata[`PBC_USR_BIT_ON];
  assign newSel = usrWdata[`PBC_USR_BIT_SEL];
  assign splitNeeded = (newOn != shadowOn) && (newSel != shadowSel);
  assign enableRefused = newOn && !shadowOn && !lowWritten;

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= pbc_pkg::CT_IDLE;
      regPort.regWr <= 1'b0;
      regPort.regRd <= 1'b0;
      regPort.regAddr <= `PBC_ADDR_LOOP_CONTROL;
      regPort.regWdata <= 8'h00;
      secondData <= 8'h00;
      shadowOn <= 1'b1;
      shadowSel <= 1'b0;
      shadowExp <= `PBC_RST_EXP;
      shadowMultHigh <= `PBC_RST_MULT_HIGH;
      shadowMultLow <= `PBC_RST_MULT_LOW;
      shadowRange <= `PBC_RST_VCO_RANGE;
      lowWritten <= 1'b0;
      cmdError <= 1'b0;
    end
    else
    begin
      regPort.regWr <= 1'b0;
      regPort.regRd <= 1'b0;
      unique case (state)
        pbc_pkg::CT_IDLE:
        begin
          if (usrWr)
          begin
            cmdError <= 1'b0;
            regPort.regWr <= 1'b1;
            unique case (usrAddr)
              `PBC_USR_CTRL:
              begin
                if (enableRefused) // RULE14
                begin
                  regPort.regWr <= 1'b0;
                  cmdError <= 1'b1;
                end
                else
                begin
                  shadowOn <= newOn;
                  shadowSel <= newSel;
                  regPort.regAddr <= `PBC_ADDR_LOOP_CONTROL;
                  secondData <= {2'h0, newOn, newSel, 2'h0, shadowExp};
                  // Selecting: loop first. Deselecting: source first.
                  if (splitNeeded && newSel) // RULE8
                  begin
                    regPort.regWdata <= {2'h0, newOn, shadowSel, 2'h0, shadowExp};
                    state <= pbc_pkg::CT_SECOND;
                  end
                  else if (splitNeeded) // RULE8
                  begin
                    regPort.regWdata <= {2'h0, shadowOn, newSel, 2'h0, shadowExp};
                    state <= pbc_pkg::CT_SECOND;
                  end
                  else
                  begin
                    regPort.regWdata <= {2'h0, newOn, newSel, 2'h0, shadowExp};
                  end
                end
              end
              `PBC_USR_EXP:
              begin
                if (usrWdata[1:0] == `PBC_EXP_FORBIDDEN) // RULE12
                begin
                  regPort.regWr <= 1'b0;
                  cmdError <= 1'b1;
                end
                else
                begin
                  shadowExp <= usrWdata[1:0];
                  regPort.regAddr <= `PBC_ADDR_LOOP_CONTROL;
                  regPort.regWdata <= {2'h0, shadowOn, shadowSel, 2'h0, usrWdata[1:0]}; // RULE11
                end
              end
              `PBC_USR_MULT_HIGH:
              begin
                shadowMultHigh <= usrWdata[3:0];
                regPort.regAddr <= `PBC_ADDR_MULT_HIGH;
                regPort.regWdata <= {4'h0, usrWdata[3:0]}; // RULE13 RULE10
              end
              `PBC_USR_MULT_LOW:
              begin
                shadowMultLow <= usrWdata;
                lowWritten <= 1'b1; // RULE14
                regPort.regAddr <= `PBC_ADDR_MULT_LOW;
                regPort.regWdata <= usrWdata; // RULE13 RULE10
              end
              `PBC_USR_RANGE:
              begin
                shadowRange <= usrWdata;
                regPort.regAddr <= `PBC_ADDR_VCO_RANGE;
                regPort.regWdata <= usrWdata; // RULE15
              end
              default:
              begin
                regPort.regWr <= 1'b0;
                cmdError <= 1'b1;
              end
            endcase
          end
          else
          begin
            // Idle cycles poll the device control register for status.
            regPort.regRd <= 1'b1;
            regPort.regAddr <= `PBC_ADDR_LOOP_CONTROL;
          end
        end
        pbc_pkg::CT_SECOND:
        begin
          regPort.regWr <= 1'b1; // RULE8
          regPort.regWdata <= secondData;
          state <= pbc_pkg::CT_IDLE;
        end
        default:
        begin
          state <= pbc_pkg::CT_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Device status capture and user read port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdSeen <= 1'b0;
      devControl <= 8'h00;
    end
    else
    begin
      rdSeen <= regPort.regRd;
      if (rdSeen)
      begin
        devControl <= regPort.regRdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      usrRdata <= 8'h00;
    end
    else if (usrRd)
    begin
      unique case (usrAddr)
        `PBC_USR_CTRL: usrRdata <= {6'h00, shadowSel, shadowOn};
        `PBC_USR_EXP: usrRdata <= {6'h00, shadowExp};
        `PBC_USR_MULT_HIGH: usrRdata <= {4'h0, shadowMultHigh};
        `PBC_USR_MULT_LOW: usrRdata <= shadowMultLow;
        `PBC_USR_RANGE: usrRdata <= shadowRange;
        `PBC_USR_STATUS: usrRdata <= {state != pbc_pkg::CT_IDLE, cmdError, devControl[5:0]};
        default: usrRdata <= 8'h00;
      endcase
    end
    else
    begin
      usrRdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// ==== bench/pbc_clock_gen_sva.sv ====
// Checker for the register port and the base clock selector outputs.
`timescale 1ns/100ps
`default_nettype none
`include "pbc_consts.svh"

module pbc_clock_gen_sva (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic baseClockOut,
  input wire logic loopEnable,
  input wire logic [11:0] feedbackMultiplier,
  input wire logic [7:0] linearRange,
  input wire logic vcoActive,
  input wire logic switching
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_rdata_after_read:
    assert property (regRdata != 8'h00 |-> $past(regRd))
    else $error("read data outside its cycle");
  a_mult_never_zero:
    assert property (feedbackMultiplier != 12'h000)
    else $error("multiplier presented as zero");
  a_range_zero_off:
    assert property (linearRange == 8'h00 |-> !loopEnable)
    else $error("loop enabled with zero range");
  a_switch_held_static:
    assert property (switching && $past(switching) |-> $stable(baseClockOut))
    else $error("base clock moved during a source change");
  a_half_rate_toggle:
    assert property ($changed(baseClockOut) && !switching |=> !$changed(baseClockOut) [*3]
      ##[1:40] ($changed(baseClockOut) || switching))
    else $error("base clock toggle spacing wrong");
  a_select_starts_switch:
    assert property (regWr && regAddr == `PBC_ADDR_LOOP_CONTROL && regWdata[4] && loopEnable
      && !vcoActive && !switching |-> ##[1:4] switching)
    else $error("select did not start a source change");
  a_vco_needs_loop:
    assert property ($rose(vcoActive) |-> loopEnable)
    else $error("vco taken while loop disabled");
  a_prog_locked:
    assert property (regWr && regAddr == `PBC_ADDR_MULT_LOW && loopEnable
      |=> $stable(feedbackMultiplier) [*3])
    else $error("multiplier changed while loop on");
  a_reset_state:
    assert property (!$past(rst_n) |-> !vcoActive ##[0:2] loopEnable)
    else $error("wrong state after reset");
endmodule

`default_nettype wire

// ==== bench/pbc_clock_gen_tb.sv ====
// Testbench joining the controller and the clock generator control.
`timescale 1ns/100ps
`default_nettype none
`include "pbc_consts.svh"

module pbc_clock_gen_tb;
  typedef struct {
    logic [2:0] a;
    logic [7:0] d;
    logic [11:0] m;
    logic [1:0] e;
    logic [7:0] r;
  } pbc_row_type;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic crystalClock = 1'b0;
  logic vcoClock = 1'b0;
  logic [2:0] usrAddr = 3'h0;
  logic [7:0] usrWdata = 8'h00;
  logic usrWr = 1'b0;
  logic usrRd = 1'b0;
  logic [7:0] usrRdata;
  logic baseClockOut;
  logic loopEnable;
  logic vcoActive;
  logic switching;
  logic [11:0] feedbackMultiplier;
  logic [1:0] rangeExponent;
  logic [7:0] linearRange;
  logic [7:0] st;
  int miscompares = 0;
  int total_checks = 0;
  pbc_row_type rows [7];

  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end
  initial forever #100 crystalClock = ~crystalClock;
  // The offset keeps the VCO edges off the system clock edges.
  initial
  begin
    #5;
    forever #70 vcoClock = ~vcoClock;
  end

  pbc_reg_if pbc_reg_if_inst ();

  pbc_clock_gen pbc_clock_gen_inst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .regPort(pbc_reg_if_inst.device),
    .crystalClock(crystalClock),
    .vcoClock(vcoClock),
    .baseClockOut(baseClockOut),
    .loopEnable(loopEnable),
    .feedbackMultiplier(feedbackMultiplier),
    .rangeExponent(rangeExponent),
    .linearRange(linearRange),
    .vcoActive(vcoActive),
    .switching(switching)
  );

  pbc_controller pbc_controller_inst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .regPort(pbc_reg_if_inst.ctrl),
    .usrAddr(usrAddr),
    .usrWdata(usrWdata),
    .usrWr(usrWr),
    .usrRd(usrRd),
    .usrRdata(usrRdata)
  );

  pbc_clock_gen_sva pbc_clock_gen_sva_inst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .regAddr(pbc_reg_if_inst.regAddr),
    .regWdata(pbc_reg_if_inst.regWdata),
    .regWr(pbc_reg_if_inst.regWr),
    .regRd(pbc_reg_if_inst.regRd),
    .regRdata(pbc_reg_if_inst.regRdata),
    .baseClockOut(baseClockOut),
    .loopEnable(loopEnable),
    .feedbackMultiplier(feedbackMultiplier),
    .linearRange(linearRange),
    .vcoActive(vcoActive),
    .switching(switching)
  );

  // ----
  // Shared tasks
  // ----
  task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
    total_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, s);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic uWr(input logic [2:0] a, input logic [7:0] d);
    usrAddr <= a;
    usrWdata <= d;
    usrWr <= 1'b1;
    @(posedge sys_clk);
    usrWr <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic uRd(input logic [2:0] a);
    repeat (4) @(posedge sys_clk);
    usrAddr <= a;
    usrRd <= 1'b1;
    @(posedge sys_clk);
    usrRd <= 1'b0;
    @(negedge sys_clk);
    st = usrRdata;
    @(posedge sys_clk);
  endtask

  task automatic waitSw(input logic v);
    int i;
    for (i = 0; i < 300 && !(vcoActive === v && switching === 1'b0); i++)
      @(posedge sys_clk);
    if (i == 300)
    begin
      miscompares++;
      conclude();
    end
  endtask

  // Measures the cycles between two output toggles; the first wait finds a toggle.
  task automatic togGap(input string n, input logic [11:0] e);
    logic prev;
    int c;
    for (int j = 0; j < 2; j++)
    begin
      prev = baseClockOut;
      for (c = 0; c < 40 && baseClockOut === prev; c++)
        @(posedge sys_clk);
      if (c == 40)
      begin
        miscompares++;
        conclude();
      end
    end
    chk(n, 12'(c), e);
  endtask

  task automatic doReset();
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("loop", 12'(loopEnable), 12'h001);
    chk("mult", feedbackMultiplier, 12'h040);
    chk("range", 12'(linearRange), 12'h040);
    chk("vco", 12'(vcoActive), 12'h000);
    togGap("xgap", 12'h00A);
    uRd(`PBC_USR_STATUS);
    chk("ctl", 12'(st[5:0]), 12'h020);
    $display("reset test done");
  endtask

  // ----
  // Main sequence
  // ----
  initial
  begin
    rows[0] = '{`PBC_USR_MULT_HIGH, 8'h02, 12'h240, 2'h0, 8'h40};
    rows[1] = '{`PBC_USR_MULT_LOW, 8'h00, 12'h200, 2'h0, 8'h40};
    rows[2] = '{`PBC_USR_MULT_HIGH, 8'h00, 12'h001, 2'h0, 8'h40};
    // The last rows set a 20 MHz VCO for a 5 MHz bus from a 4 MHz reference.
    rows[3] = '{`PBC_USR_MULT_LOW, 8'h05, 12'h005, 2'h0, 8'h40};
    rows[4] = '{`PBC_USR_EXP, 8'h01, 12'h005, 2'h1, 8'h40};
    rows[5] = '{`PBC_USR_EXP, 8'h02, 12'h005, 2'h2, 8'h40};
    rows[6] = '{`PBC_USR_RANGE, 8'h46, 12'h005, 2'h2, 8'h46};
    doReset();
    uWr(`PBC_USR_CTRL, 8'h00);
    chk("off", 12'(loopEnable), 12'h000);
    for (int k = 0; k < 7; k++)
    begin
      uWr(rows[k].a, rows[k].d);
      chk("mult", feedbackMultiplier, rows[k].m);
      chk("exp", 12'(rangeExponent), 12'(rows[k].e));
      chk("range", 12'(linearRange), 12'(rows[k].r));
      $display("row %0d done", k);
    end
    uWr(`PBC_USR_EXP, 8'h03);
    chk("exp3", 12'(rangeExponent), 12'h002);
    uRd(`PBC_USR_STATUS);
    chk("err", 12'(st[6]), 12'h001);
    $display("refused exponent done");
    uWr(`PBC_USR_CTRL, 8'h01);
    chk("on", 12'(loopEnable), 12'h001);
    chk("xtal", 12'(vcoActive), 12'h000);
    uWr(`PBC_USR_CTRL, 8'h03);
    waitSw(1'b1);
    togGap("vgap", 12'h007);
    uRd(`PBC_USR_STATUS);
    chk("sel", 12'(st[5:0]), 12'h032);
    uWr(`PBC_USR_MULT_LOW, 8'h09);
    chk("locked", feedbackMultiplier, 12'h005);
    $display("vco select done");
    uWr(`PBC_USR_CTRL, 8'h00);
    waitSw(1'b0);
    uRd(`PBC_USR_STATUS);
    chk("desel", 12'(st[5:0]), 12'h002);
    chk("off2", 12'(loopEnable), 12'h000);
    $display("deselect done");
    uWr(`PBC_USR_RANGE, 8'h00);
    uWr(`PBC_USR_CTRL, 8'h01);
    uWr(`PBC_USR_CTRL, 8'h03);
    uRd(`PBC_USR_STATUS);
    chk("l0 loop", 12'(loopEnable), 12'h000);
    chk("l0 vco", 12'(vcoActive), 12'h000);
    chk("l0 sw", 12'(switching), 12'h000);
    chk("l0 sel", 12'(st[4]), 12'h000);
    $display("zero range done");
    doReset();
    uWr(`PBC_USR_CTRL, 8'h00);
    uWr(`PBC_USR_CTRL, 8'h01);
    chk("early on", 12'(loopEnable), 12'h000);
    uRd(`PBC_USR_STATUS);
    chk("early err", 12'(st[6]), 12'h001);
    chk("early dev", 12'(st[5]), 12'h000);
    $display("early enable done");
    conclude();
  end
endmodule

`default_nettype wire
